//--- rtl/bwm_top.sv
// Breaker wear monitor: remaining operations, two alarm stages, counters,
// time-stamped events and a twelve-record history behind a Wishbone slave.
// Assumes open_cmd is a one-cycle pulse with currents and consumed counts valid.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bwm_top
  import bwm_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Wishbone slave
  input  wire logic [31:0]       wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // Breaker open trigger and measurements
  input  wire logic              open_cmd,
  input  wire logic [2:0][15:0]  phase_cur,
  input  wire logic [2:0][17:0]  consumed_ops,
  input  wire logic [63:0]       ts_ms,
  // Alarm and status outputs
  output logic                   first_alarm_active,
  output logic                   second_alarm_active,
  output logic [1:0]             wear_condition_status,
  // Event buffer feed
  output logic [4:0]             evt_stb,
  output logic [63:0]            evt_ts
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      en1;
    logic                      en2;
    logic                      frc;
    logic [1:0]                fsel;
    logic [4:0]                evm;
    bwm_ops_t                  thr1;
    bwm_ops_t                  thr2;
    bwm_ops_t                  init;
    logic [2:0][BWM_OPS_W-1:0] rem;
    logic [2:0][BWM_CUR_W-1:0] cur;
    logic [2:0][BWM_OPS_W-1:0] ded;
    logic [31:0]               opcnt;
    logic [31:0]               a1cnt;
    logic [31:0]               a2cnt;
    logic                      p1;
    logic [63:0]               p1_ts;
    logic                      p2;
    logic [63:0]               p2_ts;
    logic [1:0]                cond;
    logic [4:0]                evt;
    logic [63:0]               evt_ts;
    logic                      ack;
    logic [31:0]               dat;
  } bwm_top_s;

  bwm_top_s    s_q;
  bwm_top_s    s_d;
  logic [1:0]  alarm;
  logic [1:0]  on_p;
  logic [1:0]  off_p;
  logic [1:0]  st_en;
  bwm_ops_t    st_thr [2];
  logic        hist_wr;
  bwm_rec_s    hist_rec;
  logic [31:0] hist_rd;
  logic [3:0]  hist_cnt;

  // ----------------------------------------------------------------
  // Alarm stages
  // ----------------------------------------------------------------
  assign st_en[0]  = s_q.en1;
  assign st_en[1]  = s_q.en2;
  assign st_thr[0] = s_q.thr1;
  assign st_thr[1] = s_q.thr2;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_stage
      bwm_stage u_stage (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .en        (st_en[g]),
        .thr       (st_thr[g]),
        .rem       (s_q.rem),
        .alarm     (alarm[g]),
        .on_pulse  (on_p[g]),
        .off_pulse (off_p[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // History
  // ----------------------------------------------------------------
  bwm_hist u_hist (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wr       (hist_wr),
    .wr_rec   (hist_rec),
    .rd_idx   (wb_adr_i[9:6]),
    .rd_fld   (wb_adr_i[5:2]),
    .rd_data  (hist_rd),
    .count    (hist_cnt)
  );

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] bwm_read(input bwm_top_s s, input logic [10:0] a,
                                           input logic [1:0] al, input logic [3:0] hc,
                                           input logic [31:0] hd);
    logic [31:0] r;
    r = 32'h00000000;
    if (a[BWM_HIST_BIT])
    begin
      r = hd;  // R11 R12
    end
    else
    begin
      case (a)
        BWM_A_CTRL:  r = {19'h00000, s.evm, 3'h0, s.fsel, s.frc, s.en2, s.en1};
        BWM_A_THR1:  r = {14'h0000, s.thr1};
        BWM_A_THR2:  r = {14'h0000, s.thr2};
        BWM_A_INIT:  r = {14'h0000, s.init};
        BWM_A_STAT:  r = {24'h000000, hc, al, s.cond};  // R5
        BWM_A_OPCNT: r = s.opcnt;  // R6
        BWM_A_A1CNT: r = s.a1cnt;  // R6
        BWM_A_A2CNT: r = s.a2cnt;  // R6
        BWM_A_REM1:  r = {14'h0000, s.rem[0]};  // R7
        BWM_A_REM2:  r = {14'h0000, s.rem[1]};  // R7
        BWM_A_REM3:  r = {14'h0000, s.rem[2]};  // R7
        default:     r = 32'h00000000;
      endcase
    end
    bwm_read = r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        req;
  logic        wr;
  logic        mapped;
  logic [10:0] a;
  logic [31:0] m;
  logic [31:0] ctl_old;
  logic [4:0]  ev_now;
  logic [2:0]  cmd;
  logic        load;

  always_comb
  begin
    s_d     = s_q;
    a       = wb_adr_i[10:0];
    mapped  = (wb_adr_i[31:11] == 21'h000000);
    req     = wb_cyc_i && wb_stb_i && !s_q.ack;
    wr      = req && wb_we_i && mapped;
    ctl_old = {19'h00000, s_q.evm, 3'h0, s_q.fsel, s_q.frc, s_q.en2, s_q.en1};
    m       = 32'h00000000;
    cmd     = 3'h0;
    load    = 1'b0;

    // Bus slave: one-cycle ack, unmapped reads zero, writes ignored
    s_d.ack = req;
    if (req)
    begin
      s_d.dat = mapped ? bwm_read(s_q, a, alarm, hist_cnt, hist_rd) : 32'h00000000;
    end

    if (wr && !a[BWM_HIST_BIT])
    begin
      case (a)
        BWM_A_CTRL:
        begin
          m        = bwm_merge(ctl_old, wb_dat_i, wb_sel_i);
          s_d.en1  = m[BWM_C_EN1];  // R1
          s_d.en2  = m[BWM_C_EN2];  // R1
          s_d.frc  = m[BWM_C_FRC];  // R14
          s_d.fsel = m[BWM_C_FSEL +: 2];  // R14
          s_d.evm  = m[BWM_C_EVM +: 5];  // R9
        end
        BWM_A_THR1:
        begin
          s_d.thr1 = bwm_clamp(bwm_merge({14'h0000, s_q.thr1}, wb_dat_i, wb_sel_i));  // R3
        end
        BWM_A_THR2:
        begin
          s_d.thr2 = bwm_clamp(bwm_merge({14'h0000, s_q.thr2}, wb_dat_i, wb_sel_i));  // R4
        end
        BWM_A_INIT:
        begin
          s_d.init = bwm_clamp(bwm_merge({14'h0000, s_q.init}, wb_dat_i, wb_sel_i));  // R13
        end
        BWM_A_CMD:
        begin
          if (wb_sel_i[0])
          begin
            cmd  = wb_dat_i[BWM_K_CA2:BWM_K_COPS];
            load = wb_dat_i[BWM_K_LOAD];
          end
        end
        default:
        begin
          m = 32'h00000000;
        end
      endcase
    end

    // Counter clears; a same-cycle increment still counts
    if (cmd[BWM_K_COPS])
    begin
      s_d.opcnt = 32'h00000000;  // R6
    end
    if (cmd[BWM_K_CA1])
    begin
      s_d.a1cnt = 32'h00000000;  // R6
    end
    if (cmd[BWM_K_CA2])
    begin
      s_d.a2cnt = 32'h00000000;  // R6
    end
    if (open_cmd)
    begin
      s_d.opcnt = s_d.opcnt + 32'h00000001;  // R6
    end
    if (on_p[0])
    begin
      s_d.a1cnt = s_d.a1cnt + 32'h00000001;  // R6
    end
    if (on_p[1])
    begin
      s_d.a2cnt = s_d.a2cnt + 32'h00000001;  // R6
    end

    // Remaining operations: reload, then deduct on opening
    for (int i = 0; i < 3; i++)
    begin
      if (load)
      begin
        s_d.rem[i] = s_q.init;  // R13
      end
      if (open_cmd)
      begin
        s_d.rem[i] = bwm_sat_sub(s_d.rem[i], consumed_ops[i]);  // R13 R16
        s_d.cur[i] = phase_cur[i];  // R12
        s_d.ded[i] = consumed_ops[i];  // R12
      end
    end

    // Event feed to the main buffer
    ev_now = {off_p[1], on_p[1], off_p[0], on_p[0], open_cmd};  // R8
    s_d.evt = ev_now & s_q.evm;  // R9
    if (ev_now != 5'h00)
    begin
      s_d.evt_ts = ts_ms;  // R10
    end

    // Condition status with forcing
    if (s_q.frc && (s_q.fsel == BWM_COND_A1 || s_q.fsel == BWM_COND_A2))
    begin
      s_d.cond = s_q.fsel;  // R14
    end
    else if (s_q.frc)
    begin
      s_d.cond = BWM_COND_NORM;  // R14
    end
    else
    begin
      s_d.cond = alarm[1] ? BWM_COND_A2 : alarm[0] ? BWM_COND_A1 : BWM_COND_NORM;  // R5
    end

    // History: trigger first, then held alarm ON records
    hist_wr      = 1'b0;
    hist_rec     = '0;
    hist_rec.cur = s_d.cur;
    hist_rec.ded = s_d.ded;
    hist_rec.rem = s_d.rem;
    if (open_cmd)
    begin
      hist_wr       = 1'b1;  // R11
      hist_rec.ts   = ts_ms;  // R10 R12
      hist_rec.code = BWM_CODE_TRIG;
    end
    else if (s_q.p1)
    begin
      hist_wr       = 1'b1;  // R11
      hist_rec.ts   = s_q.p1_ts;  // R10
      hist_rec.code = BWM_CODE_A1ON;
      s_d.p1        = 1'b0;
    end
    else if (s_q.p2)
    begin
      hist_wr       = 1'b1;  // R11
      hist_rec.ts   = s_q.p2_ts;  // R10
      hist_rec.code = BWM_CODE_A2ON;
      s_d.p2        = 1'b0;
    end
    if (on_p[0])
    begin
      s_d.p1    = 1'b1;
      s_d.p1_ts = ts_ms;  // R10
    end
    if (on_p[1])
    begin
      s_d.p2    = 1'b1;
      s_d.p2_ts = ts_ms;  // R10
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s_q      <= '0;
      s_q.evm  <= BWM_EVM_RST;
      s_q.thr1 <= BWM_THR1_RST;  // R3
      s_q.thr2 <= BWM_THR2_RST;  // R4
      s_q.init <= BWM_INIT_RST;
      s_q.rem  <= {3{BWM_INIT_RST}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o              = s_q.dat;
  assign wb_ack_o              = s_q.ack;
  assign first_alarm_active    = alarm[0];
  assign second_alarm_active   = alarm[1];
  assign wear_condition_status = s_q.cond;
  assign evt_stb               = s_q.evt;
  assign evt_ts                = s_q.evt_ts;

endmodule
`default_nettype wire

//--- rtl/bwm_pkg.sv
// Constants, types and helper functions shared by the breaker wear monitor.
// Assumes one 40 MHz core clock and a classic Wishbone register bus.
//
// How it works
// R1 - Each alarm stage has its own enable; both reset disabled; disabled never alarms.
// R2 - One shared threshold per stage; picks up when any phase is below it.
// R3 - First alarm asserts while remaining below threshold; range 0..200000, default 1000.
// R4 - Second alarm likewise, own threshold, same range, default 100.
// R5 - Readable condition status: normal, first alarm active or second alarm active.
// R6 - Resettable cumulative counters for openings, first and second alarm events.
// R7 - Three readable remaining-operations values, one per phase.
// R8 - Triggered event per opening; ON and OFF events per alarm edge.
// R9 - Per-event mask chooses whether ON, OFF or both reach the event buffer.
// R10 - Every event carries the time stamp of the cycle it occurred in.
// R11 - Twelve-deep rolling history of triggered and ON-event records, oldest overwritten.
// R12 - Record holds time, event, phase currents, deducted and remaining operations.
// R13 - Each opening subtracts per-phase consumed operations from remaining counts.
// R14 - With global forcing on, a forced value overrides the condition status.
// R15 - Alarm drops with OFF event when stage disabled or no phase below threshold.
// R16 - Remaining counts saturate at zero instead of wrapping.
package bwm_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          BWM_OPS_W    = 18;
  localparam int          BWM_CUR_W    = 16;
  localparam int          BWM_HIST_N   = 12;
  localparam logic [17:0] BWM_OPS_MAX  = 18'h30D40;
  localparam logic [17:0] BWM_THR1_RST = 18'h003E8;
  localparam logic [17:0] BWM_THR2_RST = 18'h00064;
  localparam logic [17:0] BWM_INIT_RST = 18'h0C350;
  localparam logic [4:0]  BWM_EVM_RST  = 5'h1F;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [10:0] BWM_A_CTRL   = 11'h000;
  localparam logic [10:0] BWM_A_THR1   = 11'h004;
  localparam logic [10:0] BWM_A_THR2   = 11'h008;
  localparam logic [10:0] BWM_A_INIT   = 11'h00C;
  localparam logic [10:0] BWM_A_CMD    = 11'h010;
  localparam logic [10:0] BWM_A_STAT   = 11'h014;
  localparam logic [10:0] BWM_A_OPCNT  = 11'h018;
  localparam logic [10:0] BWM_A_A1CNT  = 11'h01C;
  localparam logic [10:0] BWM_A_A2CNT  = 11'h020;
  localparam logic [10:0] BWM_A_REM1   = 11'h024;
  localparam logic [10:0] BWM_A_REM2   = 11'h028;
  localparam logic [10:0] BWM_A_REM3   = 11'h02C;
  localparam int          BWM_HIST_BIT = 10;

  // ----------------------------------------------------------------
  // Control and command bit positions
  // ----------------------------------------------------------------
  localparam int BWM_C_EN1   = 0;
  localparam int BWM_C_EN2   = 1;
  localparam int BWM_C_FRC   = 2;
  localparam int BWM_C_FSEL  = 3;
  localparam int BWM_C_EVM   = 8;
  localparam int BWM_K_COPS  = 0;
  localparam int BWM_K_CA1   = 1;
  localparam int BWM_K_CA2   = 2;
  localparam int BWM_K_LOAD  = 3;

  // ----------------------------------------------------------------
  // Event indices, record codes and condition encoding
  // ----------------------------------------------------------------
  localparam int         BWM_EV_TRIG  = 0;
  localparam int         BWM_EV_A1ON  = 1;
  localparam int         BWM_EV_A1OFF = 2;
  localparam int         BWM_EV_A2ON  = 3;
  localparam int         BWM_EV_A2OFF = 4;
  localparam logic [2:0] BWM_CODE_TRIG = 3'h1;
  localparam logic [2:0] BWM_CODE_A1ON = 3'h2;
  localparam logic [2:0] BWM_CODE_A2ON = 3'h4;
  localparam logic [1:0] BWM_COND_NORM = 2'h0;
  localparam logic [1:0] BWM_COND_A1   = 2'h1;
  localparam logic [1:0] BWM_COND_A2   = 2'h2;

  typedef logic [17:0] bwm_ops_t;

  typedef struct packed {
    logic [63:0]                ts;
    logic [2:0]                 code;
    logic [2:0][BWM_CUR_W-1:0]  cur;
    logic [2:0][BWM_OPS_W-1:0]  ded;
    logic [2:0][BWM_OPS_W-1:0]  rem;
  } bwm_rec_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic bwm_any_below(input logic [2:0][17:0] rem, input bwm_ops_t thr);
    bwm_any_below = (rem[0] < thr) || (rem[1] < thr) || (rem[2] < thr);
  endfunction

  function automatic bwm_ops_t bwm_sat_sub(input bwm_ops_t a, input bwm_ops_t b);
    bwm_sat_sub = (b > a) ? 18'h00000 : a - b;
  endfunction

  function automatic bwm_ops_t bwm_clamp(input logic [31:0] v);
    bwm_clamp = (v > {14'h0000, BWM_OPS_MAX}) ? BWM_OPS_MAX : v[17:0];
  endfunction

  function automatic logic [31:0] bwm_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    bwm_merge = r;
  endfunction

endpackage

//--- rtl/bwm_stage.sv
// One alarm stage of the breaker wear monitor.
// Assumes remaining counts come from flip-flops in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module bwm_stage
  import bwm_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Settings and counts
  input  wire logic              en,
  input  wire bwm_ops_t          thr,
  input  wire logic [2:0][17:0]  rem,
  // Alarm and edge events
  output logic                   alarm,
  output logic                   on_pulse,
  output logic                   off_pulse
);

  typedef struct packed {
    logic alarm;
    logic on;
    logic off;
  } bwm_stg_s;

  bwm_stg_s s_q;
  bwm_stg_s s_d;

  always_comb
  begin
    s_d       = s_q;
    s_d.alarm = en && bwm_any_below(rem, thr);  // R1 R2 R3 R4 R15
    s_d.on    = s_d.alarm && !s_q.alarm;        // R8
    s_d.off   = !s_d.alarm && s_q.alarm;        // R8 R15
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign alarm     = s_q.alarm;
  assign on_pulse  = s_q.on;
  assign off_pulse = s_q.off;

endmodule
`default_nettype wire

//--- rtl/bwm_hist.sv
// Twelve-entry rolling history of triggered and ON-event records.
// Assumes at most one record write per clock; read port is combinational.
`timescale 1ns/1ps
`default_nettype none
module bwm_hist
  import bwm_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Record write
  input  wire logic        wr,
  input  wire bwm_rec_s    wr_rec,
  // Read by age, 0 is newest
  input  wire logic [3:0]  rd_idx,
  input  wire logic [3:0]  rd_fld,
  output logic [31:0]      rd_data,
  output logic [3:0]       count
);

  typedef struct packed {
    bwm_rec_s [BWM_HIST_N-1:0] mem;
    logic [3:0]                wptr;
    logic [3:0]                cnt;
  } bwm_hst_s;

  bwm_hst_s s_q;
  bwm_hst_s s_d;
  logic [4:0] slot;
  bwm_rec_s   rec;

  always_comb
  begin
    s_d = s_q;
    if (wr)
    begin
      s_d.mem[s_q.wptr] = wr_rec;  // R11
      s_d.wptr = (s_q.wptr == 4'(BWM_HIST_N - 1)) ? 4'h0 : s_q.wptr + 4'h1;  // R11
      if (s_q.cnt != 4'(BWM_HIST_N))
      begin
        s_d.cnt = s_q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_comb
  begin
    slot = {1'b0, s_q.wptr} + 5'h0B - {1'b0, rd_idx};
    if (slot >= 5'h0C)
    begin
      slot = slot - 5'h0C;
    end
    rec     = s_q.mem[slot[3:0]];
    rd_data = 32'h00000000;
    if (rd_idx < s_q.cnt)
    begin
      case (rd_fld)  // R12
        4'h0:    rd_data = rec.ts[31:0];
        4'h1:    rd_data = rec.ts[63:32];
        4'h2:    rd_data = {29'h00000000, rec.code};
        4'h3:    rd_data = {16'h0000, rec.cur[0]};
        4'h4:    rd_data = {16'h0000, rec.cur[1]};
        4'h5:    rd_data = {16'h0000, rec.cur[2]};
        4'h6:    rd_data = {14'h0000, rec.ded[0]};
        4'h7:    rd_data = {14'h0000, rec.ded[1]};
        4'h8:    rd_data = {14'h0000, rec.ded[2]};
        4'h9:    rd_data = {14'h0000, rec.rem[0]};
        4'hA:    rd_data = {14'h0000, rec.rem[1]};
        4'hB:    rd_data = {14'h0000, rec.rem[2]};
        default: rd_data = 32'h00000000;
      endcase
    end
  end

  assign count = s_q.cnt;

endmodule
`default_nettype wire

//--- sim/bwm_assertions.sv
// Port checker for the breaker wear monitor.
// Assumes a bind to bwm_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bwm_assertions
  import bwm_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       sys_rst,
  // Watched ports
  input wire logic       wb_we_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       open_cmd,
  input wire logic       first_alarm_active,
  input wire logic       second_alarm_active,
  input wire logic [4:0] evt_stb
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ----
  // Checks
  // ----
  logic act;
  assign act = open_cmd | (wb_cyc_i & wb_stb_i & wb_we_i);
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_trig_evt: assert property (evt_stb[0] |-> $past(open_cmd))
    else $error("triggered event without opening");
  a_a1_on: assert property (evt_stb[1] |-> $past(first_alarm_active) &&
    !$past(first_alarm_active, 2)) else $error("alarm one on event misplaced");
  a_a1_off: assert property (evt_stb[2] |-> !$past(first_alarm_active) &&
    $past(first_alarm_active, 2)) else $error("alarm one off event misplaced");
  a_a2_on: assert property (evt_stb[3] |-> $past(second_alarm_active) &&
    !$past(second_alarm_active, 2)) else $error("alarm two on event misplaced");
  a_a2_off: assert property (evt_stb[4] |-> !$past(second_alarm_active) &&
    $past(second_alarm_active, 2)) else $error("alarm two off event misplaced");
  a_al_cause: assert property ($changed(first_alarm_active) |-> $past(act) ||
    $past(act, 2) || $past(act, 3) || $past(act, 4)) else $error("alarm moved alone");
  c_open: cover property (open_cmd);
  c_a1: cover property ($rose(first_alarm_active));
  c_a2: cover property ($rose(second_alarm_active));
endmodule
`default_nettype wire

//--- sim/bwm_partner.sv
// Model of the breaker open command logic and current measurement.
// Assumes the bench asks for each opening with a one-cycle request.
`timescale 1ns/1ps
`default_nettype none
module bwm_partner
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Bench request
  input  wire logic             req,
  input  wire logic [3:0]       dly,
  input  wire logic [2:0][17:0] cons,
  input  wire logic [2:0][15:0] cur,
  // Toward the monitor, and last_ts back to the bench
  output logic                  open_cmd,
  output logic [2:0][15:0]      phase_cur,
  output logic [2:0][17:0]      consumed_ops,
  output logic [63:0]           ts_ms,
  output logic [63:0]           last_ts
);
  logic [3:0] w_q;
  logic       pend_q;
  initial
  begin
    {open_cmd, phase_cur, consumed_ops, ts_ms, last_ts, w_q, pend_q} = '0;
  end
  always @(posedge core_clk)
  begin
    ts_ms <= sys_rst ? 64'h0 : ts_ms + 64'h1;
    open_cmd <= 1'b0;
    phase_cur <= ~phase_cur;
    consumed_ops <= ~consumed_ops;
    if (sys_rst)
      pend_q <= 1'b0;
    else if (req)
    begin
      pend_q <= 1'b1;
      w_q <= dly;
    end
    else if (pend_q && w_q != 4'h0)
      w_q <= w_q - 4'h1;
    else if (pend_q)
    begin
      pend_q <= 1'b0;
      open_cmd <= 1'b1;
      phase_cur <= cur;
      consumed_ops <= cons;
      last_ts <= ts_ms + 64'h1;
    end
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the breaker wear monitor.
// Assumes the partner model drives the opening side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); num_errors++; end end
module tb
  import bwm_pkg::*;
;
  logic             core_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             we = 1'b0;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             p_req = 1'b0;
  logic [3:0]       p_dly = 4'h0;
  logic [31:0]      adr = '0;
  logic [31:0]      dat = '0;
  logic [31:0]      rd;
  logic [2:0][17:0] p_cons = '0;
  logic [2:0][15:0] p_cur = {16'h0333, 16'h0222, 16'h0111};
  wire logic [2:0][15:0] cur;
  wire logic [2:0][17:0] cons;
  wire logic [63:0] ts, last_ts, evt_ts;
  wire logic [31:0] dat_o;
  wire logic [4:0]  evt_stb;
  wire logic [1:0]  cond;
  wire logic        open, ack, al1, al2;
  int num_errors = 0;
  int tests_run = 0;
  int ev_n[5] = '{default: 0};
  logic [31:0] ra[13] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h14, 32'h18, 32'h1C,
    32'h20, 32'h24, 32'h28, 32'h2C, 32'h800, 32'h400};
  logic [31:0] re[13] = '{32'h1F00, 32'h3E8, 32'h64, 32'hC350, 32'h0, 32'h0, 32'h0,
    32'h0, 32'hC350, 32'hC350, 32'hC350, 32'h0, 32'h0};
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
    for (int i = 0; i < 5; i++)
      ev_n[i] += int'(evt_stb[i]);
  bwm_partner u_far (.core_clk(core_clk), .sys_rst(sys_rst), .req(p_req), .dly(p_dly),
    .cons(p_cons), .cur(p_cur), .open_cmd(open), .phase_cur(cur), .consumed_ops(cons),
    .ts_ms(ts), .last_ts(last_ts));
  bwm_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .open_cmd(open), .phase_cur(cur), .consumed_ops(cons), .ts_ms(ts),
    .first_alarm_active(al1), .second_alarm_active(al2), .wear_condition_status(cond),
    .evt_stb(evt_stb), .evt_ts(evt_ts));
  // ----
  // Tasks
  // ----
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge core_clk);
    end
    while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic opn(input logic [17:0] x, input logic [17:0] y, input logic [17:0] z);
    @(posedge core_clk);
    p_cons <= {z, y, x};
    p_req <= 1'b1;
    @(posedge core_clk);
    p_req <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask
  task automatic print_verdict;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #500000;
    num_errors++;
    print_verdict;
  end
  // ----
  // Sequence
  // ----
  initial
  begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 13; i++)
      rdc(ra[i], re[i]);
    wb(1'b1, 32'hC, 32'hFFFFF);
    rdc(32'hC, 32'h30D40);
    wb(1'b1, 32'hC, 32'h3E9);
    wb(1'b1, 32'h10, 32'h8);
    wb(1'b1, 32'h0, 32'h1F03);
    opn(18'h1, 18'h0, 18'h0);
    `CHK(al1, 1'b0)
    opn(18'h0, 18'h0, 18'h2);
    `CHK(al1, 1'b1)
    `CHK(ev_n[1], 1)
    rdc(32'h14, 32'h35);
    p_dly <= 4'h3;
    opn(18'h0, 18'h0, 18'h7D0);
    rdc(32'h2C, 32'h0);
    rdc(32'h24, 32'h3E8);
    rdc(32'h28, 32'h3E9);
    rdc(32'h14, 32'h5E);
    rdc(32'h18, 32'h3);
    rdc(32'h20, 32'h1);
    rdc(32'h408, 32'h4);
    rdc(32'h42C, 32'h0);
    rdc(32'h448, 32'h1);
    rdc(32'h460, 32'h7D0);
    rdc(32'h44C, 32'h111);
    rdc(32'h440, last_ts[31:0]);
    wb(1'b1, 32'h0, 32'h1F01);
    repeat (5) @(posedge core_clk);
    `CHK(al2, 1'b0)
    `CHK(ev_n[4], 1)
    wb(1'b1, 32'h10, 32'h8);
    repeat (5) @(posedge core_clk);
    `CHK(al1, 1'b0)
    `CHK(ev_n[2], 1)
    wb(1'b1, 32'h10, 32'h7);
    rdc(32'h18, 32'h0);
    rdc(32'h1C, 32'h0);
    wb(1'b1, 32'h0, 32'h1F14);
    rdc(32'h14, 32'h52);
    `CHK(cond, BWM_COND_A2)
    wb(1'b1, 32'h0, 32'h1F0C);
    rdc(32'h14, 32'h51);
    wb(1'b1, 32'h0, 32'h1D01);
    opn(18'h0, 18'h0, 18'h2);
    `CHK(al1, 1'b1)
    `CHK(ev_n[1], 1)
    `CHK(ev_n[0], 4)
    rdc(32'h14, 32'h75);
    rdc(32'h1C, 32'h1);
    wb(1'b1, 32'h8, 32'h5DC);
    repeat (5) @(posedge core_clk);
    `CHK(al2, 1'b0)
    repeat (7) opn(18'h0, 18'h0, 18'h0);
    rdc(32'h14, 32'hC5);
    `CHK(evt_ts, last_ts)
    print_verdict;
  end
endmodule
bind bwm_top bwm_assertions u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .open_cmd(open_cmd), .first_alarm_active(first_alarm_active),
  .second_alarm_active(second_alarm_active), .evt_stb(evt_stb));
`default_nettype wire
